//--- logic/ssc_ctrl.sv
// The Avalon-MM interface to the registers and the register addresses were decided locally.
module ssc_ctrl import ssc_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rxValid,
	input  wire logic [7:0]  rxData,
	output logic             rxReady,
	output logic             txValid,
	output logic [7:0]       txData,
	input  wire logic        txReady,
	output logic             authStart,
	output logic [63:0]      authAddr,
	output logic             pwdValid,
	output logic [7:0]       pwdData,
	input  wire logic        authDone,
	input  wire logic        authOk,
	input  wire logic        remLoginValid,
	input  wire logic [63:0] remAddr,
	input  wire logic [15:0] remTimeout,
	input  wire logic        remRefresh,
	output logic             remLoginAck,
	output logic             remLoginNak,
	input  wire logic        secMsgValid,
	input  wire logic [63:0] secMsgAddr,
	output logic             secMsgAllow,
	output logic [NSLOT-1:0] sessActive
);
	ssc_state_t  state_q, state_d;
	logic [15:0] len_q, idx_q, tmo_q, drops_q;
	logic [7:0]  lenHi_q, type_q, opt_q, sum_q, rspStat_q, rspCnt_q, txd_q;
	logic [63:0] dest_q;
	logic [2:0]  txIdx_q;
	logic [31:0] tickCnt_q, rd_q;
	logic        tick_q, ctrlEn_q, wait_q, rxr_q, txv_q, authStart_q, pwdv_q;
	logic [7:0]  pwdd_q, stampCtr_q;
	logic        ack_q, nak_q, allow_q;
	logic [7:0]  rspStat_d;

	logic [NSLOT-1:0] slotAct, slotYld, slotOpen, slotClose, slotHit;
	logic [63:0]      slotAddr [NSLOT];
	logic [7:0]       slotStamp [NSLOT];

	wire take    = rxValid && rxr_q;
	wire inExec  = state_q == S_EXEC;
	wire isShort = len_q < MIN_LEN;
	wire isLogout = opt_q[OPT_LOGOUT];
	wire isTerm  = !isLogout && opt_q[OPT_TERM];
	wire isLogin = !isLogout && !isTerm;
	wire isBcast = dest_q == BCAST;
	wire loginBad = isBcast || (tmo_q > TO_MAX);
	wire loginGo = inExec && !isShort && isLogin && !loginBad;
	wire [7:0] sumNext = sum_q + rxData;
	wire cksOk   = sumNext == CKS_GOOD;
	wire lastBody = idx_q == 16'(len_q - 16'h0001);
	wire txFire  = txv_q && txReady;
	wire [2:0] txIdxNext = 3'(txIdx_q + 3'h1);
	wire tickEnd = tickCnt_q == 32'(TICK_CYCLES - 1);

	function automatic logic [7:0] rspByte(input logic [2:0] i, input logic [7:0] st);
		case (i)
			3'h0:    rspByte = DELIM;
			3'h1:    rspByte = RSP_LEN[15:8];
			3'h2:    rspByte = RSP_LEN[7:0];
			3'h3:    rspByte = FT_RSP;
			3'h4:    rspByte = st;
			default: rspByte = 8'(CKS_GOOD - 8'(FT_RSP + st));
		endcase
	endfunction

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			S_IDLE: if (take && rxData == DELIM && ctrlEn_q) state_d = S_LENH;
			S_LENH: if (take) state_d = S_LENL;
			S_LENL: if (take) state_d = ({lenHi_q, rxData} == 16'h0) ? S_CSUM : S_BODY;
			S_BODY: if (take && lastBody) state_d = S_CSUM;
			S_CSUM: if (take) state_d = (cksOk && type_q == FT_REQ) ? S_EXEC : S_IDLE;
			S_EXEC: state_d = loginGo ? S_AUTH : S_RESP;
			S_AUTH: if (authDone) state_d = S_RESP;
			S_RESP: if (txFire && txIdx_q == RSP_LAST) state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	assign rspStat_d = (state_q == S_AUTH) ? (authOk ? ST_OK : ST_AUTH_FAIL)
		: ((isShort || (isLogin && loginBad)) ? ST_INVALID : ST_OK);

	// frame parser
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_IDLE;
			rxr_q   <= 1'b0;
			lenHi_q <= 8'h00;
			len_q   <= 16'h0;
			idx_q   <= 16'h0;
			sum_q   <= 8'h00;
			type_q  <= 8'h00;
			dest_q  <= 64'h0;
			opt_q   <= 8'h00;
			tmo_q   <= 16'h0;
			drops_q <= 16'h0;
		end
		else
		begin
			state_q <= state_d;
			rxr_q   <= state_d inside {S_IDLE, S_LENH, S_LENL, S_BODY, S_CSUM};
			if (take)
			begin
				case (state_q)
					S_LENH: lenHi_q <= rxData;
					S_LENL:
					begin
						len_q  <= {lenHi_q, rxData};
						idx_q  <= 16'h0;
						sum_q  <= 8'h00;
						type_q <= 8'h00;
					end
					S_BODY:
					begin
						sum_q <= sumNext;
						idx_q <= 16'(idx_q + 16'h0001);
						if (idx_q == IX_TYPE) type_q <= rxData;
						if (idx_q >= IX_DEST && idx_q < IX_OPT) dest_q <= {dest_q[55:0], rxData};
						if (idx_q == IX_OPT) opt_q <= rxData;
						if (idx_q == IX_TO_HI) tmo_q[15:8] <= rxData;
						if (idx_q == IX_TO_LO) tmo_q[7:0] <= rxData;
					end
					S_CSUM: if (!cksOk) drops_q <= 16'(drops_q + 16'h0001);
					default: ;
				endcase
			end
		end
	end

	// password bytes go to the authenticator only for a login
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwdv_q <= 1'b0;
			pwdd_q <= 8'h00;
		end
		else
		begin
			pwdv_q <= take && state_q == S_BODY && idx_q >= IX_PWD && idx_q < PWD_END
				&& !opt_q[OPT_LOGOUT] && !opt_q[OPT_TERM];
			pwdd_q <= rxData;
		end
	end

	// response generator
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txv_q       <= 1'b0;
			txd_q       <= 8'h00;
			txIdx_q     <= 3'h0;
			rspStat_q   <= ST_OK;
			rspCnt_q    <= 8'h00;
			authStart_q <= 1'b0;
		end
		else
		begin
			authStart_q <= loginGo;
			if (state_q != S_RESP && state_d == S_RESP)
			begin
				rspStat_q <= rspStat_d;
				txv_q     <= 1'b1;
				txIdx_q   <= 3'h0;
				txd_q     <= DELIM;
				rspCnt_q  <= 8'(rspCnt_q + 8'h01);
			end
			else if (txFire)
			begin
				txv_q   <= txIdx_q != RSP_LAST;
				txIdx_q <= txIdxNext;
				txd_q   <= rspByte(txIdxNext, rspStat_q);
			end
		end
	end

	// session slots: NSRV incoming, one client at CLI
	assign slotOpen[CLI]  = state_q == S_AUTH && authDone && authOk;
	assign slotClose[CLI] = inExec && !isShort && isLogout && slotAct[CLI]
		&& slotAddr[CLI] == dest_q;

	logic             freeFound, yldFound;
	logic [1:0]       freeIdx, oldIdx;
	logic [7:0]       bestAge, age;
	always_comb
	begin
		freeFound = 1'b0;
		yldFound  = 1'b0;
		freeIdx   = 2'h0;
		oldIdx    = 2'h0;
		bestAge   = 8'h00;
		age       = 8'h00;
		for (int i = 0; i < NSRV; i++)
		begin
			age = 8'(stampCtr_q - slotStamp[i]);
			if (!slotAct[i] && !freeFound)
			begin
				freeFound = 1'b1;
				freeIdx   = 2'(i);
			end
			if (slotYld[i] && (!yldFound || age > bestAge))
			begin
				yldFound = 1'b1;
				oldIdx   = 2'(i);
				bestAge  = age;
			end
		end
	end
	// a remote login during a terminate is refused so the terminate sees a stable table
	wire remGo = remLoginValid && !inExec && (freeFound || yldFound);
	wire [1:0] remIdx = freeFound ? freeIdx : oldIdx;

	for (genvar g = 0; g < NSLOT; g++)
	begin : gSlot
		if (g < NSRV)
		begin : gSrv
			assign slotOpen[g]  = remGo && remIdx == 2'(g);
			assign slotClose[g] = inExec && !isShort && isTerm && slotAct[g]
				&& (isBcast || slotAddr[g] == dest_q);
		end
		ssc_slot uSlot (
			.clk_sys     (clk_sys),
			.rst_n       (rst_n),
			.tick        (tick_q),
			.open        (slotOpen[g]),
			.openAddr    (g == CLI ? dest_q : remAddr),
			.openTo      (g == CLI ? tmo_q : remTimeout),
			.openRefresh (g == CLI ? opt_q[OPT_REFRESH] : remRefresh),
			.openStamp   (stampCtr_q),
			.close       (slotClose[g]),
			.msgValid    (secMsgValid),
			.msgAddr     (secMsgAddr),
			.active      (slotAct[g]),
			.yielding    (slotYld[g]),
			.addr        (slotAddr[g]),
			.stamp       (slotStamp[g])
		);
		assign slotHit[g] = slotAct[g] && slotAddr[g] == secMsgAddr;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tickCnt_q  <= 32'h0;
			tick_q     <= 1'b0;
			stampCtr_q <= 8'h00;
			ack_q      <= 1'b0;
			nak_q      <= 1'b0;
			allow_q    <= 1'b0;
		end
		else
		begin
			tickCnt_q <= tickEnd ? 32'h0 : 32'(tickCnt_q + 32'h1);
			tick_q    <= tickEnd;
			if (remGo) stampCtr_q <= 8'(stampCtr_q + 8'h01);
			ack_q   <= remGo;
			nak_q   <= remLoginValid && !remGo;
			allow_q <= secMsgValid && (|slotHit);
		end
	end

	// avalon slave: one wait state on every access
	wire busHit  = (avs_read || avs_write) && wait_q;
	wire wrCtrl  = avs_write && !wait_q && avs_address == A_CTRL;
	wire [31:0] rdMux = (avs_address == A_CTRL) ? {31'h0, ctrlEn_q}
		: (avs_address == A_STAT) ? {21'h0, state_q, 3'h0, slotAct}
		: (avs_address == A_RESP) ? {16'h0, rspCnt_q, rspStat_q}
		: (avs_address == A_DROP) ? {16'h0, drops_q} : 32'h0;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_q   <= 1'b1;
			rd_q     <= 32'h0;
			ctrlEn_q <= CTRL_EN_RST;
		end
		else
		begin
			wait_q <= !busHit;
			if (busHit && avs_read) rd_q <= rdMux;
			if (wrCtrl) ctrlEn_q <= avs_writedata[0];
		end
	end

	assign avs_readdata    = rd_q;
	assign avs_waitrequest = wait_q;
	assign rxReady         = rxr_q;
	assign txValid         = txv_q;
	assign txData          = txd_q;
	assign authStart       = authStart_q;
	assign authAddr        = dest_q;
	assign pwdValid        = pwdv_q;
	assign pwdData         = pwdd_q;
	assign remLoginAck     = ack_q;
	assign remLoginNak     = nak_q;
	assign secMsgAllow     = allow_q;
	assign sessActive      = slotAct;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_route;
		state_q == S_CSUM && take && type_q != FT_REQ |=> state_q == S_IDLE;
	endproperty
	a_route: assert property (p_route) else $error("foreign frame type acted on");
	property p_rsp_type;
		txv_q && txIdx_q == 3'h3 |-> txd_q == FT_RSP;
	endproperty
	a_rsp_type: assert property (p_rsp_type) else $error("response type byte wrong");
	property p_bcast_login;
		inExec && isLogin && isBcast |=> state_q == S_RESP && rspStat_q == ST_INVALID
			&& !authStart_q;
	endproperty
	a_bcast_login: assert property (p_bcast_login) else $error("broadcast login not refused");
	property p_len_zero;
		state_q == S_LENL && take && lenHi_q == 8'h00 && rxData == 8'h00 |=> state_q == S_CSUM;
	endproperty
	a_len_zero: assert property (p_len_zero) else $error("empty body not skipped");
	property p_cks;
		state_q == S_CSUM && take && !cksOk |=> state_q == S_IDLE ##1 !txv_q;
	endproperty
	a_cks: assert property (p_cks) else $error("bad checksum frame accepted");
	property p_term_all;
		inExec && !isShort && isTerm && isBcast |=> slotAct[NSRV-1:0] == 4'h0;
	endproperty
	a_term_all: assert property (p_term_all) else $error("broadcast terminate left sessions");
	property p_logout;
		inExec && !isShort && isLogout |=> state_q == S_RESP && !authStart_q ##1 !pwdv_q;
	endproperty
	a_logout: assert property (p_logout) else $error("logout started authentication");
	property p_login;
		loginGo |=> authStart_q && state_q == S_AUTH;
	endproperty
	a_login: assert property (p_login) else $error("valid login did not start auth");
	property p_tomax;
		inExec && !isShort && isLogin && tmo_q > TO_MAX |=> rspStat_q == ST_INVALID;
	endproperty
	a_tomax: assert property (p_tomax) else $error("over-limit timeout accepted");
	property p_allow;
		allow_q |-> $past(secMsgValid) && $past(|slotAct);
	endproperty
	a_allow: assert property (p_allow) else $error("secure message allowed without session");
	property p_evict;
		remLoginValid && !inExec && !freeFound && yldFound |=> remLoginAck && |slotAct[NSRV-1:0];
	endproperty
	a_evict: assert property (p_evict) else $error("yielding session not evicted");
	property p_wait;
		(avs_read || avs_write) && wait_q |=> !wait_q;
	endproperty
	a_wait: assert property (p_wait) else $error("bus access not answered");
	c_login:  cover property (state_q == S_AUTH && authDone && authOk);
	c_logout: cover property (|slotClose[CLI:CLI]);
	c_term:   cover property (inExec && isTerm && isBcast);
	c_evict:  cover property (remGo && !freeFound);
endmodule

//--- logic/ssc_pkg.sv
package ssc_pkg;
	localparam logic [7:0]  DELIM        = 8'h7e;
	localparam logic [7:0]  FT_REQ       = 8'h2e;
	localparam logic [7:0]  FT_RSP       = 8'hae;
	localparam logic [7:0]  ST_OK        = 8'h00;
	localparam logic [7:0]  ST_INVALID   = 8'h0a;
	localparam logic [7:0]  ST_AUTH_FAIL = 8'h01;
	localparam logic [7:0]  CKS_GOOD     = 8'hff;
	localparam logic [63:0] BCAST        = 64'h0000_0000_0000_ffff;
	localparam int          OPT_LOGOUT   = 0;
	localparam int          OPT_TERM     = 1;
	localparam int          OPT_REFRESH  = 2;
	localparam logic [15:0] TO_MAX       = 16'h4650;
	localparam logic [15:0] TO_NONE      = 16'h0000;
	// body index = frame offset - 3
	localparam logic [15:0] IX_TYPE      = 16'h0000;
	localparam logic [15:0] IX_DEST      = 16'h0001;
	localparam logic [15:0] IX_OPT       = 16'h0009;
	localparam logic [15:0] IX_TO_HI     = 16'h000a;
	localparam logic [15:0] IX_TO_LO     = 16'h000b;
	localparam logic [15:0] IX_PWD       = 16'h000c;
	localparam logic [15:0] PWD_END      = 16'h004c;
	localparam logic [15:0] MIN_LEN      = 16'h000c;
	localparam logic [15:0] RSP_LEN      = 16'h0002;
	localparam logic [2:0]  RSP_LAST     = 3'h5;
	localparam int          NSRV         = 4;
	localparam int          NSLOT        = 5;
	localparam int          CLI          = 4;
	localparam logic [3:0]  A_CTRL       = 4'h0;
	localparam logic [3:0]  A_STAT       = 4'h4;
	localparam logic [3:0]  A_RESP       = 4'h8;
	localparam logic [3:0]  A_DROP       = 4'hc;
	localparam logic        CTRL_EN_RST  = 1'b1;
	localparam longint      CLK_NS       = 4;
	localparam longint      TENTH_NS     = 100_000_000;
	localparam int          TICK_CYC     = int'(TENTH_NS / CLK_NS);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_LENH = 3'b001,
		S_LENL = 3'b011,
		S_BODY = 3'b010,
		S_CSUM = 3'b110,
		S_EXEC = 3'b111,
		S_AUTH = 3'b101,
		S_RESP = 3'b100
	} ssc_state_t;
endpackage

//--- logic/ssc_slot.sv
module ssc_slot import ssc_pkg::*; (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        tick,
	input  wire logic        open,
	input  wire logic [63:0] openAddr,
	input  wire logic [15:0] openTo,
	input  wire logic        openRefresh,
	input  wire logic [7:0]  openStamp,
	input  wire logic        close,
	input  wire logic        msgValid,
	input  wire logic [63:0] msgAddr,
	output logic             active,
	output logic             yielding,
	output logic [63:0]      addr,
	output logic [7:0]       stamp
);
	logic        active_q;
	logic [63:0] addr_q;
	logic [15:0] tmo_q;
	logic [15:0] rem_q;
	logic        refr_q;
	logic [7:0]  stamp_q;
	wire hit = msgValid && active_q && (msgAddr == addr_q);
	// one extra tick so that a partial first tenth never shortens the session
	wire expire = tick && active_q && (tmo_q != TO_NONE) && (rem_q == 16'h0000);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_q <= 1'b0;
			addr_q   <= 64'h0;
			tmo_q    <= 16'h0;
			rem_q    <= 16'h0;
			refr_q   <= 1'b0;
			stamp_q  <= 8'h00;
		end
		else if (close)
			active_q <= 1'b0;
		else if (open)
		begin
			active_q <= 1'b1;
			addr_q   <= openAddr;
			tmo_q    <= openTo;
			rem_q    <= openTo;
			refr_q   <= openRefresh;
			stamp_q  <= openStamp;
		end
		else if (expire)
			active_q <= 1'b0;
		else if (hit && refr_q)
			rem_q <= tmo_q;
		else if (tick && rem_q != 16'h0000)
			rem_q <= rem_q - 16'h0001;
	end

	assign active   = active_q;
	assign yielding = active_q && (tmo_q == TO_NONE);
	assign addr     = addr_q;
	assign stamp    = stamp_q;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_expire;
		expire && !close && !open |=> !active_q;
	endproperty
	a_expire: assert property (p_expire) else $error("session outlived timeout");
	property p_refresh;
		active_q && refr_q && hit && !close && !open && !expire |=> rem_q == $past(tmo_q);
	endproperty
	a_refresh: assert property (p_refresh) else $error("traffic did not restart timeout");
endmodule

//--- testbench/ssc_host_model.sv
module ssc_host_model (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	output logic            rxValid,
	output logic [7:0]      rxData,
	input  wire logic       rxReady,
	input  wire logic       txValid,
	input  wire logic [7:0] txData,
	output logic            txReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rspQ[$];
	initial
	begin
		rxValid = 1'b0;
		rxData = 8'h00;
		txReady = 1'b0;
	end
	// one byte per handshake, held until the device takes it
	task automatic send_frame(input logic [7:0] f[$], output bit ok);
		int n;
		ok = 1;
		foreach (f[i])
		begin
			rxValid <= 1'b1;
			rxData <= f[i];
			n = 0;
			do
			begin
				@(posedge clk_sys);
				n++;
			end while (rxReady !== 1'b1 && n < 200);
			if (n >= 200)
				ok = 0;
		end
		rxValid <= 1'b0;
		// a released line must not keep showing the last byte
		rxData <= ~rxData;
	endtask
	// random stalls on the response side
	always @(posedge clk_sys)
	begin
		if (txValid === 1'b1 && txReady === 1'b1)
			rspQ.push_back(txData);
		txReady <= ($urandom_range(3) != 0);
	end
endmodule

//--- testbench/testbench.sv
module testbench import ssc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 10;
	typedef logic [7:0] ssc_bq_t[$];
	logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, rxValid, rxReady;
	logic        txValid, txReady, authStart, pwdValid, authDone, authOk, remLoginValid;
	logic        remRefresh, remLoginAck, remLoginNak, secMsgValid, secMsgAllow, cliOn, aok, en;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [7:0]  rxData, txData, pwdData, lastSt;
	logic [63:0] authAddr, remAddr, secMsgAddr, cliA, cA;
	logic [15:0] remTimeout, t;
	logic [4:0]  sessActive;
	logic [2:0]  authDly;
	logic [63:0] inq[$];
	bit          inz[$];
	logic [7:0]  pwdQ[$];
	int          n_errors, tests_run, nResp;
	ssc_bq_t     fq;
	bit          okf;

	ssc_ctrl #(.TICK_CYCLES(TICK)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rxValid(rxValid), .rxData(rxData),
		.rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
		.authStart(authStart), .authAddr(authAddr), .pwdValid(pwdValid), .pwdData(pwdData),
		.authDone(authDone), .authOk(authOk), .remLoginValid(remLoginValid),
		.remAddr(remAddr), .remTimeout(remTimeout), .remRefresh(remRefresh),
		.remLoginAck(remLoginAck), .remLoginNak(remLoginNak), .secMsgValid(secMsgValid),
		.secMsgAddr(secMsgAddr), .secMsgAllow(secMsgAllow), .sessActive(sessActive));
	ssc_host_model host_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData),
		.rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady));

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// authentication partner: answers four cycles after the start pulse rises
	always @(posedge clk_sys)
	begin
		authDly <= {authDly[1:0], authStart === 1'b1};
		authDone <= authDly[2];
		authOk <= aok;
		if (pwdValid === 1'b1)
			pwdQ.push_back(pwdData);
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic hang();
		n_errors++;
		stop_test();
	endtask
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			hang();
		@(posedge clk_sys);
	endtask
	function automatic ssc_bq_t mk(input logic [7:0] ty, input logic [63:0] d,
		input logic [7:0] o, input logic [15:0] tv, input int np, input bit bad);
		ssc_bq_t f;
		logic [7:0] s;
		logic [15:0] n;
		n = 16'(12 + np);
		f = {ty};
		for (int i = 7; i >= 0; i--)
			f.push_back(d[i*8 +: 8]);
		f.push_back(o);
		f.push_back(tv[15:8]);
		f.push_back(tv[7:0]);
		for (int i = 0; i < np; i++)
			f.push_back(8'(8'h61 + i));
		s = 8'hff;
		foreach (f[i])
			s -= f[i];
		f.push_back(s ^ {7'h00, bad});
		f.push_front(n[7:0]);
		f.push_front(n[15:8]);
		f.push_front(DELIM);
		return f;
	endfunction
	function automatic logic [7:0] exp_st(input logic [63:0] d, input logic [7:0] o,
		input logic [15:0] tv);
		if (o[1:0] != 2'b00)
			return ST_OK;
		if (d == BCAST || tv > TO_MAX)
			return ST_INVALID;
		return aok ? ST_OK : ST_AUTH_FAIL;
	endfunction
	task automatic chk_rsp(input logic [7:0] st);
		logic [7:0] ex[6];
		int n;
		ex = '{DELIM, 8'h00, RSP_LEN[7:0], FT_RSP, st, 8'(8'hff - FT_RSP - st)};
		n = 0;
		while (host_u.rspQ.size() < 6 && n < 2000)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 2000)
			hang();
		foreach (ex[i])
			chk("rsp", ex[i], host_u.rspQ[i]);
		nResp++;
		lastSt = st;
	endtask
	task automatic req(input logic [7:0] ty, input logic [63:0] d, input logic [7:0] o,
		input logic [15:0] tv, input int np, input bit bad);
		bit ok;
		logic [7:0] st;
		host_u.rspQ.delete();
		pwdQ.delete();
		host_u.send_frame(mk(ty, d, o, tv, np, bad), ok);
		if (!ok)
			hang();
		if (bad || ty != FT_REQ || !en)
		begin
			repeat (30) @(posedge clk_sys);
			chk("none", 0, host_u.rspQ.size());
			return;
		end
		st = exp_st(d, o, tv);
		chk_rsp(st);
		if (o[1:0] != 2'b00)
			chk("pwdn", 0, pwdQ.size());
		else if (st != ST_INVALID)
		begin
			chk("addr", d, authAddr);
			chk("pwdn", np, pwdQ.size());
			foreach (pwdQ[i])
				chk("pwd", 8'(8'h61 + i), pwdQ[i]);
		end
		if (o[0])
			cliOn = (cliOn && d != cliA);
		else if (o[1])
		begin
			for (int i = inq.size() - 1; i >= 0; i--)
				if (d == BCAST || inq[i] == d)
				begin
					inq.delete(i);
					inz.delete(i);
				end
		end
		else if (st == ST_OK)
		begin
			cliOn = 1;
			cliA = d;
		end
	endtask
	task automatic rem(input logic [63:0] a, input logic [15:0] tv, input bit r);
		int k;
		remAddr <= a;
		remTimeout <= tv;
		remRefresh <= r;
		remLoginValid <= 1'b1;
		@(posedge clk_sys);
		remLoginValid <= 1'b0;
		k = -1;
		foreach (inz[i])
			if (k < 0 && inz[i])
				k = i;
		if (inq.size() == NSRV && k >= 0)
		begin
			inq.delete(k);
			inz.delete(k);
		end
		@(posedge clk_sys);
		chk("ack", inq.size() < NSRV, remLoginAck);
		chk("nak", inq.size() >= NSRV, remLoginNak);
		if (inq.size() < NSRV)
		begin
			inq.push_back(a);
			inz.push_back(tv == TO_NONE);
		end
	endtask
	task automatic sec(input logic [63:0] a, input bit e);
		secMsgAddr <= a;
		secMsgValid <= 1'b1;
		@(posedge clk_sys);
		secMsgValid <= 1'b0;
		@(posedge clk_sys);
		chk("allow", e, secMsgAllow);
	endtask
	task automatic chk_sess();
		repeat (2) @(posedge clk_sys);
		// a plain sum keeps an unknown slot bit visible, where a bit count would drop it
		chk("srv", inq.size(), sessActive[0] + sessActive[1] + sessActive[2] + sessActive[3]);
		chk("cli", cliOn, sessActive[4]);
	endtask

	initial
	begin
		repeat (90000) @(posedge clk_sys);
		hang();
	end
	initial
	begin
		rst_n = 1'b0;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		{authDone, authOk, authDly, remLoginValid, remAddr, remTimeout, remRefresh} = '0;
		{secMsgValid, secMsgAddr, cliOn, cliA, nResp, lastSt} = '0;
		{aok, en} = 2'b11;
		void'($urandom(32'h5463));
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		bus(0, A_CTRL, 0, q);
		chk("ctrl", CTRL_EN_RST, q[0]);
		bus(0, 4'h2, 0, q);
		chk("unmapped", 0, q);
		cA = {$urandom, $urandom | 32'h0001_0000};
		t = 16'($urandom_range(16'h4650, 16'h1000));
		req(FT_REQ, cA, 8'h00, t, 5, 0);
		chk_sess();
		sec(cA, 1);
		sec(cA ^ 64'h1, 0);
		req(FT_REQ, cA, 8'h07, 16'hffff, 3, 0);
		chk_sess();
		sec(cA, 0);
		req(FT_REQ, BCAST, 8'h00, 16'h0100, 2, 0);
		req(FT_REQ, cA, 8'h04, 16'h4651, 2, 0);
		aok = 0;
		req(FT_REQ, cA, 8'h00, TO_MAX, 2, 0);
		aok = 1;
		req(FT_REQ, cA, 8'h01, 0, 0, 1);
		req(8'h2d, cA, 8'h01, 0, 0, 0);
		bus(0, A_DROP, 0, q);
		chk("drop", 1, q[15:0]);
		bus(1, A_CTRL, 0, q);
		en = 0;
		req(FT_REQ, cA, 8'h00, t, 1, 0);
		bus(1, A_CTRL, 1, q);
		en = 1;
		// empty body goes straight to the checksum and, carrying no type, is dropped
		host_u.rspQ.delete();
		fq = {DELIM, 8'h00, 8'h00, CKS_GOOD};
		host_u.send_frame(fq, okf);
		chk("sent", 1, okf);
		repeat (30) @(posedge clk_sys);
		chk("empty", 0, host_u.rspQ.size());
		// a body too short to hold the fields is answered as invalid
		fq = {DELIM, 8'h00, 8'h01, FT_REQ, 8'(CKS_GOOD - FT_REQ)};
		host_u.send_frame(fq, okf);
		chk("sent", 1, okf);
		chk_rsp(ST_INVALID);
		for (int i = 0; i < 6; i++)
			rem(64'h100 + i, (i == 1) ? TO_NONE : TO_MAX, 0);
		chk_sess();
		// all four incoming slots are taken and the parser is idle
		bus(0, A_STAT, 0, q);
		chk("stat", {S_IDLE, 3'h0, cliOn, 4'hf}, q);
		req(FT_REQ, 64'h103, 8'h02, 0, 4, 0);
		chk_sess();
		req(FT_REQ, BCAST, 8'h0a, 0, 0, 0);
		chk_sess();
		// fixed timeout of two tenths: three ticks must pass before it closes
		rem(64'h200, 16'h0002, 0);
		repeat (12) @(posedge clk_sys);
		chk_sess();
		repeat (30) @(posedge clk_sys);
		inq.delete();
		inz.delete();
		chk_sess();
		rem(64'h300, 16'h0002, 1);
		repeat (6)
		begin
			repeat (12) @(posedge clk_sys);
			sec(64'h300, 1);
		end
		inq.delete();
		inz.delete();
		repeat (40) @(posedge clk_sys);
		chk_sess();
		bus(0, A_RESP, 0, q);
		chk("resp", {nResp[7:0], lastSt}, q[15:0]);
		stop_test();
	end
endmodule
